// ### core/pea_core.sv
// Phase-aligned power, low-pass filter and 40-bit energy accumulator
// ==============================================================
// Overview of operation
// - Phase calibration byte signed, clamped 9Eh..5Ch
// - One calibration step equals one sample update
// - Time shift applied to voltage path only
// - Negative calibration advances the voltage path
// - Power equals current times aligned voltage
// - Low-pass filter yields active power
// - Power gain word scales active power range
// - Active power summed into 40-bit accumulator
// - Accumulator updates every four clock cycles
// - Signed addition lets negative power subtract
// - Accumulator wraps on overflow and underflow
// - Source 00 with sample enable gives power
// - Waveform rate selectable among four rates
// - Half-full and wrap raise enableable interrupts
// - Gain is one plus word over 4096
// - Interrupt low on each new waveform sample
`timescale 1ns/10ps
module pea_core #(
	parameter int SAMPLE_W  = pea_pkg::SAMPLE_W,
	parameter int LPF_SHIFT = pea_pkg::LPF_SHIFT
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Converter samples, taken on each update
	input  wire logic [SAMPLE_W-1:0] current_sample_i,
	input  wire logic [SAMPLE_W-1:0] voltage_sample_i,
	// Calibration and mode settings
	input  wire logic                phase_cal_wr_i,
	input  wire logic [7:0]          phase_cal_wdata_i,
	input  wire logic [11:0]         power_gain_word_i,
	input  wire logic [1:0]          wave_src_i,
	input  wire logic [1:0]          wave_rate_i,
	input  wire logic [3:0]          irq_enable_i,
	input  wire logic                status_clear_i,
	// Readback and events
	output logic      [7:0]          phase_delay_cal_o,
	output logic      [39:0]         energy_accumulator_o,
	output logic      [23:0]         waveform_o,
	output logic                     sample_strobe_o,
	output logic      [3:0]          status_o,
	output logic                     irq_n_o
);
	// ==========================================================
	// Declarations
	logic [1:0]          upd_cnt_reg;
	logic                upd_reg;
	logic [7:0]          cal_reg;
	logic [7:0]          cal_next;
	logic [SAMPLE_W-1:0] cur_dly;
	logic [SAMPLE_W-1:0] volt_dly;
	logic [8:0]          vdelay_sum;
	logic [39:0]         prod_full;
	logic [23:0]         prod_reg;
	logic [13:0]         gain_factor;
	logic [37:0]         gained_full;
	logic [23:0]         gained_reg;
	logic [24:0]         lpf_diff;
	logic [24:0]         lpf_step;
	logic [23:0]         lpf_reg;
	logic [23:0]         lpf_next;
	logic [39:0]         power_ext;
	logic [39:0]         acc_reg;
	logic [39:0]         acc_next;
	logic                ev_pos_half;
	logic                ev_neg_half;
	logic                ev_wrap;
	logic [8:0]          wave_cnt_reg;
	logic [8:0]          wave_limit;
	logic                wave_hit;
	logic                wave_take;
	logic [23:0]         wave_reg;
	logic                strobe_reg;
	logic [3:0]          status_reg;
	logic [3:0]          status_set;
	logic [3:0]          status_next;
	logic                irq_n_reg;
	logic                cal_low;
	logic                cal_high;
	logic [8:0]          fill_cnt_reg;
	logic                primed;
	logic [23:0]         prod_take;
	logic [1:0]          acc_top;
	logic [1:0]          next_top;

	// ==========================================================
	// Update timing: one strobe per four master clocks
	// All stages move on this one strobe, so the pipeline advances
	// in lockstep and needs no valid flags between stages
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			upd_cnt_reg <= '0;
			upd_reg     <= 1'b0;
		end
		else
		begin
			upd_cnt_reg <= upd_cnt_reg + 1'b1;
			upd_reg     <= (upd_cnt_reg == pea_pkg::UPDATE_LAST);
		end
	end

	// ==========================================================
	// Phase calibration register; out-of-range writes clamp to limit
	// rather than being dropped, so software always sees a legal value
	assign cal_low  = $signed(phase_cal_wdata_i)
		< $signed(pea_pkg::CAL_MIN);
	assign cal_high = $signed(phase_cal_wdata_i)
		> $signed(pea_pkg::CAL_MAX);
	assign cal_next = cal_low  ? pea_pkg::CAL_MIN :
	                  cal_high ? pea_pkg::CAL_MAX :
	                  phase_cal_wdata_i;

	// Calibration storage, zero after reset
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cal_reg <= pea_pkg::CAL_RESET;
		else if (phase_cal_wr_i)
			cal_reg <= cal_next;
	end

	// ==========================================================
	// Alignment: current always sits at the base delay, voltage at
	// base plus the signed setting, so the most negative value still
	// leaves a non-negative depth and zero means equal alignment
	assign vdelay_sum = pea_pkg::DELAY_BASE
		+ {cal_reg[7], cal_reg};

	// Current channel: fixed base delay
	pea_delay_line #(
		.W  (SAMPLE_W),
		.AW (pea_pkg::DELAY_AW)
	) u_cur_dly (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.shift_i (upd_reg),
		.din_i   (current_sample_i),
		.delay_i (pea_pkg::DELAY_BASE[7:0]),
		.dout_o  (cur_dly)
	);

	// Voltage channel: one step per update period
	pea_delay_line #(
		.W  (SAMPLE_W),
		.AW (pea_pkg::DELAY_AW)
	) u_volt_dly (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.shift_i (upd_reg),
		.din_i   (voltage_sample_i),
		.delay_i (vdelay_sum[7:0]),
		.dout_o  (volt_dly)
	);

	// ==========================================================
	// Fill tracking: the delay memories hold no reset, so a product
	// read before every slot was written would be garbage; products
	// are held at zero for one full memory depth of updates after
	// each reset, which costs that dead time in counted energy
	assign primed = fill_cnt_reg[pea_pkg::DELAY_AW];

	// Fill counter, frozen once the memories are known to be written
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			fill_cnt_reg <= '0;
		else if (upd_reg && !primed)
			fill_cnt_reg <= fill_cnt_reg + 1'b1;
	end

	// ==========================================================
	// Instantaneous power and gain
	assign prod_full = 40'($signed(cur_dly) * $signed(volt_dly));
	assign prod_take = primed
		? prod_full[pea_pkg::PROD_SHIFT +: 24] : '0;
	// The gain factor spans 2048..6143 and is always positive, so
	// the sign of the power survives the scaling
	assign gain_factor = pea_pkg::GAIN_ONE
		+ {{2{power_gain_word_i[11]}}, power_gain_word_i};
	assign gained_full = 38'($signed(prod_reg) * $signed(gain_factor));

	// Low-pass: first-order step toward the gained product
	assign lpf_diff = {gained_reg[23], gained_reg} - {lpf_reg[23], lpf_reg};
	assign lpf_step = $signed(lpf_diff) >>> LPF_SHIFT;
	assign lpf_next = lpf_reg + lpf_step[23:0];

	// Pipeline stages advance together on each update
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prod_reg   <= '0;
			gained_reg <= '0;
			lpf_reg    <= '0;
		end
		else if (upd_reg)
		begin
			prod_reg   <= prod_take;
			gained_reg <= gained_full[pea_pkg::GAIN_SHIFT +: 24];
			lpf_reg    <= lpf_next;
		end
	end

	// ==========================================================
	// Energy accumulation; the add simply wraps at 40 bits
	assign power_ext = {{16{lpf_reg[23]}}, lpf_reg};
	assign acc_next  = acc_reg + power_ext;

	// Top two bits of the accumulator before and after the add;
	// equal top bits mean the magnitude is below a quarter of range
	assign acc_top  = acc_reg[39:38];
	assign next_top = acc_next[39:38];

	// Half-full is entry into the outer quarter of either sign; it
	// fires once on entry, not on every update spent inside
	assign ev_pos_half = upd_reg && (next_top == pea_pkg::TOP_POS_HALF)
		&& (acc_top != pea_pkg::TOP_POS_HALF);
	assign ev_neg_half = upd_reg && (next_top == pea_pkg::TOP_NEG_HALF)
		&& (acc_top != pea_pkg::TOP_NEG_HALF);

	// Wrap: two operands of one sign giving a sum of the other sign.
	// No saturation here, so a host that tracks long totals must
	// count wraps through the flag itself
	assign ev_wrap = upd_reg && (acc_reg[39] == power_ext[39])
		&& (acc_next[39] != acc_reg[39]);

	// Accumulator register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			acc_reg <= '0;
		else if (upd_reg)
			acc_reg <= acc_next;
	end

	// ==========================================================
	// Waveform decimation: base rate is every 32 updates, halved per
	// step of the rate select. The count runs even while no sample is
	// taken, so re-enabling the source keeps to the same rate grid
	assign wave_limit = (pea_pkg::WAVE_BASE_DIV << wave_rate_i)
		- 1'b1;
	assign wave_hit  = upd_reg && (wave_cnt_reg >= wave_limit);
	assign wave_take = wave_hit && (wave_src_i == pea_pkg::WAVE_SRC_POWER)
		&& irq_enable_i[pea_pkg::ST_SAMPLE];

	// Rate counter and sample register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wave_cnt_reg <= '0;
			wave_reg     <= '0;
			strobe_reg   <= 1'b0;
		end
		else
		begin
			strobe_reg <= wave_take;
			if (wave_hit)
				wave_cnt_reg <= '0;
			else if (upd_reg)
				wave_cnt_reg <= wave_cnt_reg + 1'b1;
			if (wave_take)
				wave_reg <= lpf_reg;
		end
	end

	// ==========================================================
	// Sticky status; a new event wins over a clear in the same cycle
	// Enables gate only the pin for half-full and wrap: those events are recorded so a host
	// can poll them with the pin masked; a sample is taken only with its enable bit set
	assign status_set  = {wave_take, ev_wrap, ev_neg_half, ev_pos_half};
	assign status_next = (status_clear_i ? 4'h0 : status_reg) | status_set;

	// Status and interrupt line, active low while any enabled bit is set
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			status_reg <= '0;
			irq_n_reg  <= 1'b1;
		end
		else
		begin
			status_reg <= status_next;
			irq_n_reg  <= ~|(status_next & irq_enable_i);
		end
	end

	// ==========================================================
	// Outputs straight from registers, so a host never sees a
	// half-formed sum in the middle of an update
	assign phase_delay_cal_o    = cal_reg;
	assign energy_accumulator_o = acc_reg;
	assign waveform_o           = wave_reg;
	assign sample_strobe_o      = strobe_reg;
	assign status_o             = status_reg;
	assign irq_n_o              = irq_n_reg;
endmodule

// ### core/pea_delay_line.sv
// Programmable sample delay line with a circular array
`timescale 1ns/10ps
module pea_delay_line #(
	parameter int W  = 20,
	parameter int AW = 8
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Sample stream
	input  wire logic          shift_i,
	input  wire logic [W-1:0]  din_i,
	input  wire logic [AW-1:0] delay_i,
	output logic      [W-1:0]  dout_o
);
	// ==========================================================
	// Storage
	logic [W-1:0]  mem [0:(1<<AW)-1];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] wp_next;
	logic [AW-1:0] rd_addr;

	// Read back the sample written delay_i updates ago
	assign wp_next = wp_reg + 1'b1;
	assign rd_addr = wp_reg - 1'b1 - delay_i;
	assign dout_o  = mem[rd_addr];

	// Write pointer; the array itself holds no reset
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			wp_reg <= '0;
		else if (shift_i)
			wp_reg <= wp_next;
	end

	// Sample store
	always_ff @(posedge clk_i)
	begin
		if (shift_i)
			mem[wp_reg] <= din_i;
	end
endmodule

// ### core/pea_pkg.sv
// Constants shared by the power and energy accumulator datapath
package pea_pkg;
	// ==========================================================
	// Sample and word widths
	localparam int SAMPLE_W = 20;
	localparam int CAL_W    = 8;
	localparam int GAIN_W   = 12;
	localparam int POWER_W  = 24;
	localparam int ENERGY_W = 40;
	localparam int DELAY_AW = 8;

	// ==========================================================
	// Phase calibration limits and reset values
	localparam logic [7:0] CAL_MIN     = 8'h9e;
	localparam logic [7:0] CAL_MAX     = 8'h5c;
	localparam logic [7:0] CAL_RESET   = 8'h00;
	localparam logic [8:0] DELAY_BASE  = 9'h062;

	// ==========================================================
	// Timing: one sample update every four master clocks
	localparam int         UPDATE_CYCLES = 4;
	localparam logic [1:0] UPDATE_LAST   = 2'h3;

	// ==========================================================
	// Arithmetic scaling
	localparam logic [13:0] GAIN_ONE   = 14'h1000;
	localparam int          GAIN_SHIFT = 12;
	localparam int          PROD_SHIFT = 16;
	localparam int          LPF_SHIFT  = 4;

	// ==========================================================
	// Waveform source, rate and status bit positions
	localparam logic [1:0] WAVE_SRC_POWER = 2'h0;
	localparam logic [8:0] WAVE_BASE_DIV  = 9'h020;
	localparam int ST_POS_HALF = 0;
	localparam int ST_NEG_HALF = 1;
	localparam int ST_WRAP     = 2;
	localparam int ST_SAMPLE   = 3;
	localparam int ST_W        = 4;

	// ==========================================================
	// Accumulator sign pairs that mark the outer quarter of a sign
	localparam logic [1:0] TOP_POS_HALF = 2'h1;
	localparam logic [1:0] TOP_NEG_HALF = 2'h2;
endpackage

// ### dv/pea_core_props.sv
// Port checker of the power and energy accumulator
`timescale 1ns/10ps
module pea_core_props (
	// Clock, reset and settings
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        phase_cal_wr_i,
	input wire logic [7:0]  phase_cal_wdata_i,
	input wire logic [1:0]  wave_src_i,
	input wire logic [3:0]  irq_enable_i,
	input wire logic        status_clear_i,
	// Readback and events
	input wire logic [7:0]  phase_delay_cal_o,
	input wire logic [39:0] energy_accumulator_o,
	input wire logic [23:0] waveform_o,
	input wire logic        sample_strobe_o,
	input wire logic [3:0]  status_o,
	input wire logic        irq_n_o
);
	logic [7:0] clamp_w;
	logic [1:0] top_w;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// Expected clamp and sign-pair of the accumulator
	assign clamp_w = $signed(phase_cal_wdata_i) < $signed(8'h9e) ? 8'h9e :
		$signed(phase_cal_wdata_i) > $signed(8'h5c) ? 8'h5c : phase_cal_wdata_i;
	assign top_w = energy_accumulator_o[39:38];
	cal_clamp_a: assert property (
		phase_cal_wr_i |=> phase_delay_cal_o == $past(clamp_w))
		else $error("calibration not the clamped write");
	cal_hold_a: assert property (
		!phase_cal_wr_i |=> $stable(phase_delay_cal_o))
		else $error("calibration moved without write");
	acc_period_a: assert property (
		$changed(energy_accumulator_o) |=> $stable(energy_accumulator_o)[*3])
		else $error("accumulator updated faster than every four");
	acc_wrap_a: assert property (
		top_w == ~$past(top_w) && ^top_w |-> ##[0:1] status_o[2])
		else $error("wrap without wrap flag");
	status_sticky_a: assert property (
		!status_clear_i |=> (status_o & $past(status_o)) == $past(status_o))
		else $error("status bit dropped without clear");
	irq_level_a: assert property (
		irq_n_o == !(|(status_o & $past(irq_enable_i))))
		else $error("irq not status and enable");
	strobe_pulse_a: assert property (
		sample_strobe_o |=> !sample_strobe_o)
		else $error("sample strobe longer than one cycle");
	strobe_src_a: assert property (
		sample_strobe_o |-> $past(wave_src_i) == 2'h0 &&
		$past(irq_enable_i[3]) && status_o[3])
		else $error("sample taken without power source and enable");
	wave_hold_a: assert property (
		$changed(waveform_o) |-> sample_strobe_o)
		else $error("waveform changed without strobe");
endmodule

bind pea_core pea_core_props i_props (.clk_i(clk_i), .rst_i(rst_i),
	.phase_cal_wr_i(phase_cal_wr_i), .phase_cal_wdata_i(phase_cal_wdata_i),
	.wave_src_i(wave_src_i), .irq_enable_i(irq_enable_i),
	.status_clear_i(status_clear_i), .phase_delay_cal_o(phase_delay_cal_o),
	.energy_accumulator_o(energy_accumulator_o), .waveform_o(waveform_o),
	.sample_strobe_o(sample_strobe_o), .status_o(status_o), .irq_n_o(irq_n_o));

// ### dv/pea_host_model.sv
// Host model that programs the calibration byte
`timescale 1ns/10ps
module pea_host_model (
	// Clock
	input  wire logic clk_i,
	// Calibration write
	output logic       wr_o,
	output logic [7:0] wdata_o
);
	initial
	begin
		wr_o = 1'b0;
		wdata_o = 8'h00;
	end
	// One-cycle write; data is inverted once released so late sampling shows
	task automatic write_cal(input logic [7:0] v);
		@(negedge clk_i);
		wr_o = 1'b1;
		wdata_o = v;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~v;
	endtask
endmodule

// ### dv/power_energy_accumulator_tb_top.sv
// Self-checking bench of the power and energy accumulator
`timescale 1ns/10ps
module power_energy_accumulator_tb_top;
	typedef struct {logic [19:0] c; logic [19:0] v; logic [11:0] g;
		logic [39:0] x;} pea_row_t;
	logic        clk = 1'b0, rst = 1'b1, clr = 1'b0, wr, stb, irq_n;
	logic [19:0] cur = 20'h40000, volt = 20'h40000;
	logic [11:0] gain = 12'h000;
	logic [1:0]  src = 2'h0, rate = 2'h0;
	logic [3:0]  en = 4'h8, st;
	logic [7:0]  wd, cal;
	logic [39:0] acc, d;
	logic [23:0] wave;
	int          n_fail = 0, checks = 0, n;
	// Gain rows: unity, largest range, smallest range, negative power
	pea_row_t    rows [4] = '{'{20'h40000, 20'h40000, 12'h000, 40'h100000},
		'{20'h40000, 20'h40000, 12'h7ff, 40'h17ff00},
		'{20'h40000, 20'h40000, 12'h800, 40'h080000},
		'{20'hc0000, 20'h40000, 12'h000, 40'hfffff00000}};
	logic [15:0] ct [7] = '{16'h809e, 16'h9d9e, 16'h9e9e, 16'h5c5c,
		16'h5d5c, 16'hfcfc, 16'h0000};
	pea_host_model i_host (.clk_i(clk), .wr_o(wr), .wdata_o(wd));
	pea_core i_dut (.clk_i(clk), .rst_i(rst), .current_sample_i(cur),
		.voltage_sample_i(volt), .phase_cal_wr_i(wr), .phase_cal_wdata_i(wd),
		.power_gain_word_i(gain), .wave_src_i(src), .wave_rate_i(rate),
		.irq_enable_i(en), .status_clear_i(clr), .phase_delay_cal_o(cal),
		.energy_accumulator_o(acc), .waveform_o(wave), .sample_strobe_o(stb),
		.status_o(st), .irq_n_o(irq_n));
	// ==========
	// Clock, checks and helpers
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [39:0] e, g);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Filter settles up to 15 below its input, never above
	function automatic logic [39:0] near(input logic [39:0] x, g);
		return (x - g <= 40'd15) ? g : x;
	endfunction
	task automatic step();
		logic [39:0] a;
		a = acc;
		repeat (4) @(negedge clk);
		d = acc - a;
	endtask
	task automatic wstb();
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (stb !== 1'b1 && n < 3000);
	endtask
	task automatic end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog well above the expected run of about 26k cycles
	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
	// Main sequence; delay memories are unreset, so fill them, then reset
	initial
	begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (1100) @(negedge clk);
		rst = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("cal", 40'h0, {32'h0, cal});
		chk("acc", 40'h0, acc);
		foreach (ct[i])
		begin
			i_host.write_cal(ct[i][15:8]);
			chk("cal", {32'h0, ct[i][7:0]}, {32'h0, cal});
		end
		$display("test reset and clamp done");
		foreach (rows[i])
		begin
			cur = rows[i].c;
			gain = rows[i].g;
			repeat (2400) @(negedge clk);
			step();
			chk("step", near(rows[i].x, d), d);
			wstb();
			d = {{16{wave[23]}}, wave};
			chk("wave", near(rows[i].x, d), d);
			chk("irq", 40'h0, {39'h0, irq_n});
		end
		$display("test power rows done");
		cur = 20'h40000;
		for (int k = 0; k < 2; k++)
		begin
			i_host.write_cal(k ? 8'h00 : 8'h9e);
			volt = 20'h40000;
			repeat (2400) @(negedge clk);
			volt = 20'h0;
			repeat (40) @(negedge clk);
			step();
			chk("advance", {39'h0, !k}, {39'h0, d < 40'hf0000});
		end
		$display("test phase shift done");
		for (int r = 0; r < 4; r++)
		begin
			rate = r[1:0];
			wstb();
			wstb();
			chk("spacing", 40'd128 << r, n);
		end
		$display("test rates done");
		en = 4'h0;
		@(negedge clk);
		chk("irq", 40'h1, {39'h0, irq_n});
		chk("status", 40'h8, {36'h0, st});
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		chk("status", 40'h0, {36'h0, st});
		rate = 2'h0;
		wstb();
		chk("no sample", 40'd3000, n);
		src = 2'h1;
		en = 4'h8;
		wstb();
		chk("no sample", 40'd3000, n);
		$display("test irq and source done");
		end_of_test();
	end
endmodule
